// ### core/rcc_pkg.sv
// Functional notes
// - Any reset source except break enters system reset
// - Oscillator stop declared after 3 ms
// - Four watchdog periods; reset on second overflow
// - Break reset touches only the core
// - Cause flags survive all resets but power-on; cause bit set
// - Bit 0 set on power up
// - Bit 1 set on oscillator stop
// - No detector: bit 1 reads zero
// - Bit 2 set on watchdog reset
// - Pin reset leaves cause flags alone
// - System reset overrides all activity
// - Non-break reset initialises power and registers
// - Core vectors 0000H, 0002H or 0004H
//
// Purpose: constants and types of the reset cause controller
// Assumes: 100 MHz system clock, 16-bit register address
// Notes:   cause flags live in reset_cause_flags at 0xf001
package rcc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] ADDR_CAUSE    = 16'hf001;
  localparam logic [15:0] ADDR_CTRL     = 16'hf0f0;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'hf0f1;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hf0f2;
  // Cause flag positions and layout
  localparam int          CAUSE_POR_BIT = 0;
  localparam int          CAUSE_OSC_BIT = 1;
  localparam int          CAUSE_WDT_BIT = 2;
  localparam logic [7:0]  CAUSE_RST_VAL = 8'h01;
  localparam logic [7:0]  CAUSE_MASK    = 8'h07;
  // Interrupt status layout
  localparam int          IRQ_WDT1_BIT  = 0;
  localparam int          IRQ_BRK_BIT   = 1;
  localparam logic [7:0]  IRQ_MASK_BITS = 8'h03;
  localparam logic [7:0]  CTRL_MASK     = 8'h03;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ         = 100;
  localparam int OSC_STOP_TIME_US = 3000;
  localparam int OSC_STOP_CYC    = OSC_STOP_TIME_US * CLK_MHZ;
  localparam int RST_HOLD_CYC    = 16;
  // ****************************************
  // Core vectors
  // ****************************************
  localparam logic [15:0] VEC_SP     = 16'h0000;
  localparam logic [15:0] VEC_PC     = 16'h0002;
  localparam logic [15:0] VEC_PC_BRK = 16'h0004;
  localparam logic [1:0]  BRK_LVL_MAX = 2'h1;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    WDT_250MS, WDT_1S, WDT_4S, WDT_16S
  } rcc_wdt_per_e;
  typedef enum logic [1:0] {
    ST_RUN, ST_SYS_RST, ST_CPU_RST
  } rcc_state_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } rcc_bus_req_s;
  typedef struct packed {
    logic sys_rst_n;
    logic cpu_rst_n;
    logic pwr_rst_n;
  } rcc_rst_out_s;
endpackage : rcc_pkg

// ### core/rcc_reset_ctrl.sv
// Purpose: reset merging, hold and cause recording
// Assumes: all inputs synchronous to sys_clk; arst_n is power-on
// Notes:   cause flags are cleared only by power-on or software
`timescale 1ns/100ps
module rcc_reset_ctrl #(
  parameter int       OSC_STOP_CYC = rcc_pkg::OSC_STOP_CYC,
  parameter int       HOLD_CYC     = rcc_pkg::RST_HOLD_CYC,
  parameter bit       HAS_OSC_DET  = 1'b1
) (
  input  wire logic                 sys_clk,       // 100 MHz clock
  input  wire logic                 arst_n,        // Power-on reset
  input  wire rcc_pkg::rcc_bus_req_s bus_req,      // Register request
  output logic [7:0]                bus_rdata,     // Read data
  input  wire logic                 ext_rst_n,     // Reset pin level
  input  wire logic                 lsosc_in,      // Low-speed osc
  input  wire logic                 wdt_ovf,       // Overflow pulse
  input  wire logic                 wdt_clr,       // Counter cleared
  input  wire logic                 brk_exec,      // Break executed
  input  wire logic [1:0]           cpu_int_level, // Core level
  output rcc_pkg::rcc_rst_out_s     rst_out,       // Reset outputs
  output rcc_pkg::rcc_wdt_per_e     wdt_period,    // Period select
  output logic [15:0]               sp_vec_addr,   // SP vector
  output logic [15:0]               pc_vec_addr,   // PC vector
  output logic                      irq            // Interrupt
);
  localparam int OW = $clog2(OSC_STOP_CYC + 1);
  localparam int HW = $clog2(HOLD_CYC + 1);

  rcc_pkg::rcc_state_e state_reg;
  logic [HW-1:0]       hold_cnt_reg;
  logic [OW-1:0]       osc_cnt_reg;
  logic                lsosc_d_reg;
  logic                wdt_armed_reg;
  logic                brk_low_reg;
  logic [7:0]          cause_reg;
  logic [7:0]          cause_next;
  logic [7:0]          ctrl_reg;
  logic [7:0]          irq_stat_reg;
  logic [7:0]          irq_mask_reg;
  logic [7:0]          irq_set;
  logic                osc_stop_det;
  logic                wdt_rst_req;
  logic                sys_cause;
  logic                sfr_init;
  logic                cause_wr;

  // Address match for one register access
  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] b);
    hit = (a == b);
  endfunction : hit

  // ****************************************
  // Reset sources
  // ****************************************
  // Oscillator stop: no edge on the low-speed input for the
  // detection time; counter restarts on every edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lsosc_d_reg <= 1'b0;
      osc_cnt_reg <= '0;
    end else begin
      lsosc_d_reg <= lsosc_in;
      if (lsosc_in != lsosc_d_reg || state_reg == rcc_pkg::ST_SYS_RST ||
          osc_stop_det) begin
        osc_cnt_reg <= '0;
      end else begin
        osc_cnt_reg <= osc_cnt_reg + OW'(1);
      end
    end
  end

  // Detector absent: the source is tied off entirely
  assign osc_stop_det = HAS_OSC_DET &&
                        (osc_cnt_reg == OW'(OSC_STOP_CYC - 1));

  // First overflow only arms; the second one resets. An overflow
  // that meets a counter clear still arms, so none slips past
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_armed_reg <= 1'b0;
    end else if (sfr_init) begin
      wdt_armed_reg <= 1'b0;
    end else if (wdt_ovf) begin
      wdt_armed_reg <= 1'b1;
    end else if (wdt_clr) begin
      wdt_armed_reg <= 1'b0;
    end
  end

  assign wdt_rst_req = wdt_ovf && wdt_armed_reg;
  assign sys_cause   = !ext_rst_n || osc_stop_det || wdt_rst_req;

  // ****************************************
  // Reset sequencer
  // ****************************************
  // Power-on lands in system reset; a system cause wins over
  // everything, including a break reset in progress
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= rcc_pkg::ST_SYS_RST;
      hold_cnt_reg <= HW'(HOLD_CYC);
    end else begin
      case (state_reg)
        rcc_pkg::ST_RUN: begin
          if (sys_cause) begin
            state_reg    <= rcc_pkg::ST_SYS_RST;
            hold_cnt_reg <= HW'(HOLD_CYC);
          end else if (brk_exec) begin
            state_reg    <= rcc_pkg::ST_CPU_RST;
            hold_cnt_reg <= HW'(HOLD_CYC);
          end
        end
        rcc_pkg::ST_SYS_RST, rcc_pkg::ST_CPU_RST: begin
          if (sys_cause) begin
            state_reg    <= rcc_pkg::ST_SYS_RST;
            hold_cnt_reg <= HW'(HOLD_CYC);
          end else if (hold_cnt_reg == '0) begin
            state_reg    <= rcc_pkg::ST_RUN;
          end else begin
            hold_cnt_reg <= hold_cnt_reg - HW'(1);
          end
        end
        default: begin
          state_reg <= rcc_pkg::ST_SYS_RST;
        end
      endcase
    end
  end

  // Break leaves power circuit and registers alone
  assign sfr_init          = (state_reg == rcc_pkg::ST_SYS_RST);
  assign rst_out.sys_rst_n = !sfr_init;
  assign rst_out.pwr_rst_n = !sfr_init;
  assign rst_out.cpu_rst_n = (state_reg == rcc_pkg::ST_RUN);

  // Interrupt level is caught when the break starts
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      brk_low_reg <= 1'b0;
    end else if (sfr_init) begin
      brk_low_reg <= 1'b0;
    end else if (state_reg == rcc_pkg::ST_RUN && !sys_cause &&
                 brk_exec) begin
      brk_low_reg <= (cpu_int_level <= rcc_pkg::BRK_LVL_MAX);
    end
  end

  // Vector addresses for the core's restart fetch
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_vec_addr <= rcc_pkg::VEC_SP;
      pc_vec_addr <= rcc_pkg::VEC_PC;
    end else begin
      sp_vec_addr <= rcc_pkg::VEC_SP;
      pc_vec_addr <= brk_low_reg ? rcc_pkg::VEC_PC_BRK
                                 : rcc_pkg::VEC_PC;
    end
  end

  // ****************************************
  // Cause flags
  // ****************************************
  assign cause_wr = bus_req.wr && hit(bus_req.addr, rcc_pkg::ADDR_CAUSE);

  // Write loads, then hardware sets on top so a cause is never lost;
  // the pin has no flag of its own
  always_comb begin
    cause_next = cause_reg;
    if (cause_wr) begin
      cause_next = bus_req.wdata & rcc_pkg::CAUSE_MASK;
    end
    if (osc_stop_det) begin
      cause_next[rcc_pkg::CAUSE_OSC_BIT] = 1'b1;
    end
    if (wdt_rst_req) begin
      cause_next[rcc_pkg::CAUSE_WDT_BIT] = 1'b1;
    end
    if (!HAS_OSC_DET) begin
      cause_next[rcc_pkg::CAUSE_OSC_BIT] = 1'b0;
    end
  end

  // Only power-on touches this register at reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_reg <= rcc_pkg::CAUSE_RST_VAL;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // ****************************************
  // Control and interrupt registers
  // ****************************************
  // Ordinary registers return to defaults on system reset only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg     <= 8'h00;
      irq_mask_reg <= 8'h00;
    end else if (sfr_init) begin
      ctrl_reg     <= 8'h00;
      irq_mask_reg <= 8'h00;
    end else if (bus_req.wr) begin
      if (hit(bus_req.addr, rcc_pkg::ADDR_CTRL)) begin
        ctrl_reg <= bus_req.wdata & rcc_pkg::CTRL_MASK;
      end
      if (hit(bus_req.addr, rcc_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_reg <= bus_req.wdata & rcc_pkg::IRQ_MASK_BITS;
      end
    end
  end

  assign wdt_period = rcc_pkg::rcc_wdt_per_e'(ctrl_reg[1:0]);

  // Status events: first overflow and an accepted break
  always_comb begin
    irq_set = 8'h00;
    irq_set[rcc_pkg::IRQ_WDT1_BIT] = wdt_ovf && !wdt_armed_reg;
    irq_set[rcc_pkg::IRQ_BRK_BIT]  = state_reg == rcc_pkg::ST_RUN &&
                                     !sys_cause && brk_exec;
  end

  // Read clears the status; an event in that cycle still sets
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg <= 8'h00;
    end else if (sfr_init) begin
      irq_stat_reg <= 8'h00;
    end else if (bus_req.rd &&
                 hit(bus_req.addr, rcc_pkg::ADDR_IRQ_STAT)) begin
      irq_stat_reg <= irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  // Level output, high while any unmasked status bit is set
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= 8'h00;
    end else if (!bus_req.rd) begin
      bus_rdata <= 8'h00;
    end else if (hit(bus_req.addr, rcc_pkg::ADDR_CAUSE)) begin
      bus_rdata <= cause_reg;
    end else if (hit(bus_req.addr, rcc_pkg::ADDR_CTRL)) begin
      bus_rdata <= ctrl_reg;
    end else if (hit(bus_req.addr, rcc_pkg::ADDR_IRQ_STAT)) begin
      bus_rdata <= irq_stat_reg;
    end else if (hit(bus_req.addr, rcc_pkg::ADDR_IRQ_MASK)) begin
      bus_rdata <= irq_mask_reg;
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_SYS_ENTRY: assert property (
    sys_cause |=> state_reg == rcc_pkg::ST_SYS_RST ##1 !rst_out.sys_rst_n)
    else $error("system cause did not hold reset");
  AST_WDT_SECOND: assert property (
    wdt_ovf && !sfr_init |=> wdt_armed_reg && (!wdt_ovf || wdt_rst_req))
    else $error("second overflow gave no reset");
  AST_WDT_FIRST: assert property (
    state_reg == rcc_pkg::ST_RUN && wdt_ovf && !wdt_armed_reg &&
      ext_rst_n && !osc_stop_det && !brk_exec
      |=> state_reg == rcc_pkg::ST_RUN)
    else $error("first overflow caused reset");
  AST_OSC_FLAG: assert property (
    osc_stop_det |=> cause_reg[rcc_pkg::CAUSE_OSC_BIT] &&
      state_reg == rcc_pkg::ST_SYS_RST)
    else $error("oscillator stop not recorded");
  AST_NO_OSC_BIT: assert property (
    !HAS_OSC_DET |-> !cause_reg[rcc_pkg::CAUSE_OSC_BIT])
    else $error("oscillator flag set without detector");
  AST_BRK_CORE: assert property (
    state_reg == rcc_pkg::ST_CPU_RST |->
      rst_out.sys_rst_n && rst_out.pwr_rst_n && !rst_out.cpu_rst_n)
    else $error("break reset reached registers");
  AST_WDT_FLAG: assert property (
    wdt_rst_req |=> cause_reg[rcc_pkg::CAUSE_WDT_BIT])
    else $error("watchdog flag missing");
  AST_KEEP: assert property (
    !cause_wr |=> (cause_reg & $past(cause_reg)) == $past(cause_reg))
    else $error("cause flag lost without a write");
  AST_PIN_ONLY: assert property (
    !ext_rst_n && !osc_stop_det && !wdt_rst_req && !cause_wr
      |=> $stable(cause_reg))
    else $error("pin reset changed cause flags");
  AST_PC_VEC: assert property (
    state_reg == rcc_pkg::ST_RUN && !sys_cause && brk_exec
      |=> ##1 pc_vec_addr ==
      (($past(cpu_int_level, 2) <= rcc_pkg::BRK_LVL_MAX) ?
       rcc_pkg::VEC_PC_BRK : rcc_pkg::VEC_PC))
    else $error("wrong program counter vector");
endmodule : rcc_reset_ctrl

// ### tb/rcc_src_model.sv
// Purpose: far-side sources: reset pin, oscillator, watchdog, core
// Assumes: bench commands change just after sys_clk rises
// Notes:   oscillator toggles every third cycle unless frozen
`timescale 1ns/100ps
module rcc_src_model (
  input  wire logic       sys_clk,   // System clock
  input  wire logic       pin_low,   // Hold pin low
  input  wire logic       osc_stop,  // Freeze oscillator
  input  wire logic       ovf_req,   // Overflow request
  input  wire logic       clr_req,   // Clear request
  input  wire logic       brk_req,   // Break request
  input  wire logic [1:0] brk_lvl,   // Level at break
  output logic            ext_rst_n, // Reset pin
  output logic            lsosc_in,  // Oscillator level
  output logic            wdt_ovf,   // Overflow pulse
  output logic            wdt_clr,   // Clear pulse
  output logic            brk_exec,  // Break pulse
  output logic [1:0]      cpu_int_level // Core level
);
  logic [1:0] div_reg;
  // Idle levels at time zero
  initial begin
    {ext_rst_n, lsosc_in, wdt_ovf, wdt_clr, brk_exec} = 5'h10;
    div_reg = 2'h0;
    cpu_int_level = 2'h0;
  end
  // Level wanders outside breaks so a stale sample is not hidden
  always @(posedge sys_clk) begin
    ext_rst_n <= !pin_low;
    div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
    if (div_reg == 2'h2 && !osc_stop) lsosc_in <= !lsosc_in;
    wdt_ovf <= ovf_req;
    wdt_clr <= clr_req;
    brk_exec <= brk_req;
    cpu_int_level <= brk_req ? brk_lvl : div_reg;
  end
endmodule : rcc_src_model

// ### tb/rcc_reset_ctrl_tb.sv
// Purpose: self-checking bench of the reset cause controller
// Assumes: short oscillator-stop count, hold count of 16
// Notes:   random data from an LFSR with a fixed seed
`timescale 1ns/100ps
module rcc_reset_ctrl_tb;
  localparam int OSC_CYC = 20;
  logic                  sys_clk, arst_n, irq;
  rcc_pkg::rcc_bus_req_s bus_req;
  logic [7:0]            bus_rdata, rd_val;
  logic                  ext_rst_n, lsosc_in, wdt_ovf, wdt_clr, brk_exec;
  logic [1:0]            cpu_int_level, brk_lvl;
  rcc_pkg::rcc_rst_out_s rst_out;
  rcc_pkg::rcc_wdt_per_e wdt_period;
  logic [15:0]           sp_vec_addr, pc_vec_addr;
  logic                  pin_low, osc_stop, ovf_req, clr_req, brk_req;
  logic [31:0]           seed;
  int                    fails, checked;

  rcc_reset_ctrl #(.OSC_STOP_CYC(OSC_CYC), .HOLD_CYC(16), .HAS_OSC_DET(1'b1))
    i_rcc_reset_ctrl (.sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .ext_rst_n(ext_rst_n), .lsosc_in(lsosc_in),
    .wdt_ovf(wdt_ovf), .wdt_clr(wdt_clr), .brk_exec(brk_exec),
    .cpu_int_level(cpu_int_level), .rst_out(rst_out),
    .wdt_period(wdt_period), .sp_vec_addr(sp_vec_addr),
    .pc_vec_addr(pc_vec_addr), .irq(irq));
  rcc_src_model i_rcc_src_model (.sys_clk(sys_clk), .pin_low(pin_low),
    .osc_stop(osc_stop), .ovf_req(ovf_req), .clr_req(clr_req),
    .brk_req(brk_req), .brk_lvl(brk_lvl), .ext_rst_n(ext_rst_n),
    .lsosc_in(lsosc_in), .wdt_ovf(wdt_ovf), .wdt_clr(wdt_clr),
    .brk_exec(brk_exec), .cpu_int_level(cpu_int_level));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = !sys_clk;
  end
  // Expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [15:0] exp_pc(input logic [1:0] lvl);
    return (lvl <= 2'h1) ? rcc_pkg::VEC_PC_BRK : rcc_pkg::VEC_PC;
  endfunction : exp_pc
  // Compare tasks; flags go through the vector compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit
  // Register bus: one-cycle strobes, read data the cycle after
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : bus_wr
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 rd_val = bus_rdata;
    chk({8'h00, rd_val}, {8'h00, exp});
  endtask : rd_chk
  // Source pulses, one cycle each through the far-side model
  task automatic pulse(input int which, input logic [1:0] lvl);
    @(posedge sys_clk);
    ovf_req <= (which == 0);
    clr_req <= (which == 1);
    brk_req <= (which == 2);
    brk_lvl <= lvl;
    @(posedge sys_clk);
    {ovf_req, clr_req, brk_req} <= 3'h0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : pulse
  // Bounded wait until the core leaves reset; the outputs are read
  // one step after each edge, once the state decode has settled
  task automatic wait_run;
    repeat (200) begin
      if (rst_out.cpu_rst_n !== 1'b1) begin
        @(posedge sys_clk);
        #1;
      end
    end
    chk_bit(rst_out.sys_rst_n, 1'b1);
    chk_bit(rst_out.cpu_rst_n, 1'b1);
  endtask : wait_run
  task automatic results;
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // Watchdog: the sequence needs a few hundred cycles at most
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    results;
  end
  // Main sequence
  initial begin
    {fails, checked} = '0;
    seed = 32'haa8c0c8a;
    arst_n = 1'b0;
    bus_req = '0;
    brk_lvl = 2'h0;
    {pin_low, osc_stop, ovf_req, clr_req, brk_req} = 5'h00;
    repeat (12) @(posedge sys_clk);
    #1 chk_bit(rst_out.sys_rst_n, 1'b0);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_chk(rcc_pkg::ADDR_CAUSE, 8'h01);
    wait_run;
    chk(sp_vec_addr, rcc_pkg::VEC_SP);
    chk(pc_vec_addr, rcc_pkg::VEC_PC);
    bus_wr(rcc_pkg::ADDR_CAUSE, 8'h00);
    rd_chk(rcc_pkg::ADDR_CAUSE, 8'h00);
    rd_chk(16'h1234, 8'h00);
    // Random loads of the flags and the period select
    repeat (8) begin
      seed = lfsr(seed);
      bus_wr(rcc_pkg::ADDR_CAUSE, seed[7:0]);
      rd_chk(rcc_pkg::ADDR_CAUSE, seed[7:0] & 8'h07);
      bus_wr(rcc_pkg::ADDR_CTRL, seed[15:8]);
      #1 chk({14'h0000, wdt_period}, {14'h0000, seed[9:8]});
    end
    // Pin reset clears control but records no cause
    bus_wr(rcc_pkg::ADDR_CTRL, 8'h03);
    bus_wr(rcc_pkg::ADDR_CAUSE, 8'h00);
    @(posedge sys_clk);
    pin_low <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pin_low <= 1'b0;
    #1 chk_bit(rst_out.sys_rst_n, 1'b0);
    chk_bit(rst_out.pwr_rst_n, 1'b0);
    repeat (10) @(posedge sys_clk);
    #1 chk_bit(rst_out.cpu_rst_n, 1'b0);
    wait_run;
    chk({14'h0000, wdt_period}, 16'h0000);
    rd_chk(rcc_pkg::ADDR_CTRL, 8'h00);
    rd_chk(rcc_pkg::ADDR_CAUSE, 8'h00);
    // Watchdog: a clear between overflows disarms the second
    bus_wr(rcc_pkg::ADDR_CAUSE, 8'h01);
    bus_wr(rcc_pkg::ADDR_IRQ_MASK, 8'h01);
    pulse(0, 2'h0);
    chk_bit(irq, 1'b1);
    chk_bit(rst_out.sys_rst_n, 1'b1);
    rd_chk(rcc_pkg::ADDR_IRQ_STAT, 8'h01);
    chk_bit(irq, 1'b0);
    pulse(1, 2'h0);
    pulse(0, 2'h0);
    chk_bit(rst_out.sys_rst_n, 1'b1);
    pulse(0, 2'h0);
    chk_bit(rst_out.sys_rst_n, 1'b0);
    wait_run;
    rd_chk(rcc_pkg::ADDR_CAUSE, 8'h05);
    rd_chk(rcc_pkg::ADDR_IRQ_MASK, 8'h00);
    // Oscillator stop: no reset early, reset after the count
    bus_wr(rcc_pkg::ADDR_CAUSE, 8'h00);
    osc_stop <= 1'b1;
    repeat (OSC_CYC - 6) @(posedge sys_clk);
    #1 chk_bit(rst_out.sys_rst_n, 1'b1);
    repeat (14) @(posedge sys_clk);
    osc_stop <= 1'b0;
    #1 chk_bit(rst_out.sys_rst_n, 1'b0);
    wait_run;
    rd_chk(rcc_pkg::ADDR_CAUSE, 8'h02);
    // Break at every level: core only, registers kept
    bus_wr(rcc_pkg::ADDR_CTRL, 8'h02);
    bus_wr(rcc_pkg::ADDR_IRQ_MASK, 8'h01);
    for (int l = 0; l < 4; l++) begin
      pulse(2, l[1:0]);
      chk_bit(rst_out.cpu_rst_n, 1'b0);
      chk_bit(rst_out.sys_rst_n, 1'b1);
      chk_bit(rst_out.pwr_rst_n, 1'b1);
      chk(pc_vec_addr, exp_pc(l[1:0]));
      chk_bit(irq, 1'b0);
      wait_run;
      rd_chk(rcc_pkg::ADDR_CTRL, 8'h02);
      rd_chk(rcc_pkg::ADDR_IRQ_STAT, 8'h02);
      rd_chk(rcc_pkg::ADDR_CAUSE, 8'h02);
    end
    // Status register ignores writes
    bus_wr(rcc_pkg::ADDR_IRQ_STAT, 8'hff);
    rd_chk(rcc_pkg::ADDR_IRQ_STAT, 8'h00);
    results;
  end
endmodule : rcc_reset_ctrl_tb
